// ---- logic/rmc_defs.vh ----
`ifndef RMC_DEFS_VH
`define RMC_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define RMC_IDX_FILL1     8'hA1
`define RMC_IDX_FILL2     8'hA2
`define RMC_IDX_FILL3     8'hA3
`define RMC_IDX_S2REF     8'hBE
`define RMC_IDX_S3CFG     8'hC0
`define RMC_IDX_GPIOCFG   8'hC1
`define RMC_IDX_CRCCTL    8'hF0
`define RMC_IDX_CRCSTAT   8'hF1
`define RMC_IDX_S3REF     8'hF2
`define RMC_IDX_GPIOSTAT  8'hF3

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define RMC_RST_ZERO      16'h0000
`define RMC_RST_GPIOCFG   16'h8000
`define RMC_MASK_FILL2    16'hFF00
`define RMC_MASK_S3CFG    16'h8007
`define RMC_MASK_GPIOCFG  16'h7FFF
`define RMC_MASK_CRCCTL   16'h0001

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RMC_S3_EN_BIT     15
`define RMC_TDAC_MSB      2
`define RMC_P1_FMT_BIT    11
`define RMC_P0_FMT_BIT    10
`define RMC_P1_DIR_BIT    9
`define RMC_P0_DIR_BIT    8
`define RMC_P1_TB_LSB     6
`define RMC_P0_TB_LSB     4
`define RMC_P1_DAT_BIT    1
`define RMC_P0_DAT_BIT    0
`define RMC_ERR2_BIT      0
`define RMC_ERR3_BIT      1

// ----------------------------------------------------------------
// crc and timing
// ----------------------------------------------------------------
`define RMC_CRC_POLY      16'h1021
`define RMC_CRC_INIT      16'hFFFF
`define RMC_MCLK_DIV      15
`define RMC_TB_BASE       16

`endif

// ---- logic/rmc_pwm_decode.v ----
`timescale 1ns/100ps
`include "rmc_defs.vh"

// ----------------------------------------------------------------
// pwm input decoder: majority of high samples over one time base
// ----------------------------------------------------------------
module rmc_pwm_decode (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       mclk_en,
  input  wire [1:0] timebase,
  input  wire       sample,
  output reg        level
);

  reg  [10:0] win_cnt;
  reg  [10:0] high_cnt;
  wire [10:0] win_len;

  // 16, 64, 256 or 1024 master clock periods [R08]
  assign win_len = 11'd16 << {timebase, 1'b0};

  // count window and high samples, decide at window end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      win_cnt  <= 11'h000;
      high_cnt <= 11'h000;
      level    <= 1'b0;
    end else if (mclk_en) begin
      if (win_cnt >= win_len - 11'd1) begin
        win_cnt  <= 11'h000;
        high_cnt <= 11'h000;
        level    <= ((high_cnt + {10'h000, sample}) > (win_len >> 1)); // [R08]
      end else begin
        win_cnt  <= win_cnt + 11'd1;
        high_cnt <= high_cnt + {10'h000, sample};
      end
    end
  end

endmodule

// ---- logic/rmc_regbank.v ----
`timescale 1ns/100ps
`include "rmc_defs.vh"

// How it works
// R01: filler words A1h to A3h are plain storage covered by section 2 crc; the code stores only bits 15:8 of A2h, bits 7:0 read zero.
// R02: filler contents never steer any function; only stored and read back; the code also feeds them into the section 2 crc.
// R03: BEh holds 16-bit section 2 reference crc, reset zero.
// R04: C0h bit 15 enables section 3 crc check over C0h to E3h; the code checks only C0h and C1h.
// R05: C0h bits 2:0 pick test dac level 1,2,4,9,18,36,-4,-9 of ref/40.
// R06: C1h resets to 8000h, bit 15 reserved reading one.
// R07: bank pin direction bit 0 means input, 1 means output.
// R08: pin pwm time base code selects 16, 64, 256 or 1024 mclk periods.
// R09: enabled section crc is computed, compared with reference, error flag on mismatch.
module rmc_regbank #(
  parameter MCLK_DIV = `RMC_MCLK_DIV
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  input  wire [1:0]  gpio_in,
  output wire [1:0]  gpio_out,
  output wire [1:0]  gpio_oe,
  output wire        section3_crc_check_enable,
  output wire [2:0]  test_dac2_level_select,
  output reg  [6:0]  test_dac2_level,
  output wire        crc_error
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function [15:0] crc_word;
    input [15:0] crc;
    input [15:0] data;
    integer i;
    reg [15:0] c;
    begin
      c = crc;
      for (i = 15; i >= 0; i = i - 1) begin
        if (c[15] ^ data[i])
          c = {c[14:0], 1'b0} ^ `RMC_CRC_POLY;
        else
          c = {c[14:0], 1'b0};
      end
      crc_word = c;
    end
  endfunction

  function [15:0] merge;
    input [15:0] old;
    input [15:0] wd;
    input [1:0]  strb;
    input [15:0] mask;
    reg   [15:0] lanes;
    begin
      lanes = {{8{strb[1]}}, {8{strb[0]}}} & mask;
      merge = (old & ~lanes) | (wd & lanes);
    end
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  reg  [15:0] fill1;
  reg  [15:0] fill2;
  reg  [15:0] fill3;
  reg  [15:0] section2_crc_reference;
  reg  [15:0] s3cfg;
  reg  [15:0] gpiocfg;
  reg  [15:0] crcctl;
  reg  [15:0] s3ref;
  reg  [1:0]  err_flags;
  reg  [15:0] rd_mux;
  reg         rd_hit;
  wire [1:0]  gpio_level;

  wire [7:0]  idx      = paddr[9:2];
  wire        aligned  = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
  wire        wr_en    = psel && penable && pwrite && rd_hit;
  wire [15:0] wd       = pwdata[15:0];
  wire [1:0]  st       = pstrb[1:0];

  // ----------------------------------------------------------------
  // apb handshake: zero wait states, error on unmapped address
  // ----------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !rd_hit;

  // address decode and read mux
  always @* begin
    rd_hit = aligned;
    rd_mux = 16'h0000;
    case (idx)
      `RMC_IDX_FILL1:    rd_mux = fill1;                    // [R01]
      `RMC_IDX_FILL2:    rd_mux = fill2;                    // [R01]
      `RMC_IDX_FILL3:    rd_mux = fill3;                    // [R01]
      `RMC_IDX_S2REF:    rd_mux = section2_crc_reference;   // [R03]
      `RMC_IDX_S3CFG:    rd_mux = s3cfg;
      `RMC_IDX_GPIOCFG:  rd_mux = gpiocfg | `RMC_RST_GPIOCFG; // [R06]
      `RMC_IDX_CRCCTL:   rd_mux = crcctl;
      `RMC_IDX_CRCSTAT:  rd_mux = {14'h0000, err_flags};
      `RMC_IDX_S3REF:    rd_mux = s3ref;
      `RMC_IDX_GPIOSTAT: rd_mux = {12'h000, gpio_oe, gpio_level};
      default:           rd_hit = 1'b0;
    endcase
  end

  // read data captured in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_hit ? {16'h0000, rd_mux} : 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill1                  <= `RMC_RST_ZERO;
      fill2                  <= `RMC_RST_ZERO;
      fill3                  <= `RMC_RST_ZERO;
      section2_crc_reference <= `RMC_RST_ZERO;   // [R03]
      s3cfg                  <= `RMC_RST_ZERO;   // [R04]
      gpiocfg                <= `RMC_RST_GPIOCFG; // [R06]
      crcctl                 <= `RMC_RST_ZERO;
      s3ref                  <= `RMC_RST_ZERO;
    end else if (wr_en) begin
      case (idx)
        `RMC_IDX_FILL1:   fill1 <= merge(fill1, wd, st, 16'hFFFF);           // [R01] [R02]
        `RMC_IDX_FILL2:   fill2 <= merge(fill2, wd, st, `RMC_MASK_FILL2);    // [R01] [R02]
        `RMC_IDX_FILL3:   fill3 <= merge(fill3, wd, st, 16'hFFFF);           // [R01] [R02]
        `RMC_IDX_S2REF:   section2_crc_reference <=
                            merge(section2_crc_reference, wd, st, 16'hFFFF); // [R03]
        `RMC_IDX_S3CFG:   s3cfg <= merge(s3cfg, wd, st, `RMC_MASK_S3CFG);    // [R04] [R05]
        `RMC_IDX_GPIOCFG: gpiocfg <= merge(gpiocfg, wd, st, `RMC_MASK_GPIOCFG)
                                     | `RMC_RST_GPIOCFG;                     // [R06]
        `RMC_IDX_CRCCTL:  crcctl <= merge(crcctl, wd, st, `RMC_MASK_CRCCTL);
        `RMC_IDX_S3REF:   s3ref <= merge(s3ref, wd, st, 16'hFFFF);
        default:          crcctl <= crcctl;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // crc check of both sections
  // ----------------------------------------------------------------
  wire [15:0] crc_s2 = crc_word(crc_word(crc_word(`RMC_CRC_INIT, fill1), fill2), fill3); // [R01]
  wire [15:0] crc_s3 = crc_word(crc_word(`RMC_CRC_INIT, s3cfg), gpiocfg);
  wire        s2_on  = crcctl[0];
  wire        s3_on  = s3cfg[`RMC_S3_EN_BIT];                          // [R04]
  wire        bad2   = s2_on && (crc_s2 != section2_crc_reference);    // [R09]
  wire        bad3   = s3_on && (crc_s3 != s3ref);                     // [R09]
  wire        clr_st = wr_en && (idx == `RMC_IDX_CRCSTAT) && st[0];

  // sticky flags, write one to clear, a new mismatch wins
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      err_flags <= 2'b00;
    else
      err_flags <= (err_flags & ~(clr_st ? wd[1:0] : 2'b00)) | {bad3, bad2}; // [R09]
  end

  assign crc_error                 = |err_flags;
  assign section3_crc_check_enable = s3_on;                            // [R04]

  // ----------------------------------------------------------------
  // test dac level
  // ----------------------------------------------------------------
  assign test_dac2_level_select = s3cfg[`RMC_TDAC_MSB:0];              // [R05]

  // signed multiple of reference/40
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      test_dac2_level <= 7'h01;
    else begin
      case (test_dac2_level_select)
        3'h0:    test_dac2_level <= 7'h01;                             // [R05]
        3'h1:    test_dac2_level <= 7'h02;
        3'h2:    test_dac2_level <= 7'h04;
        3'h3:    test_dac2_level <= 7'h09;
        3'h4:    test_dac2_level <= 7'h12;
        3'h5:    test_dac2_level <= 7'h24;
        3'h6:    test_dac2_level <= 7'h7C;
        default: test_dac2_level <= 7'h77;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // bank gpio pins
  // ----------------------------------------------------------------
  reg  [1:0] in_meta;
  reg  [1:0] in_sync;
  reg  [4:0] div_cnt;
  reg        mclk_en;
  wire [1:0] pwm_level;

  // two flip-flop synchroniser and master clock enable divider
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_meta <= 2'b00;
      in_sync <= 2'b00;
      div_cnt <= 5'h00;
      mclk_en <= 1'b0;
    end else begin
      in_meta <= gpio_in;
      in_sync <= in_meta;
      mclk_en <= (div_cnt == 5'h00);
      div_cnt <= (div_cnt >= MCLK_DIV[4:0] - 5'd1) ? 5'h00 : div_cnt + 5'd1;
    end
  end

  rmc_pwm_decode u_pwm0 (
    .pclk     (pclk),
    .presetn  (presetn),
    .mclk_en  (mclk_en),
    .timebase (gpiocfg[`RMC_P0_TB_LSB+1:`RMC_P0_TB_LSB]),  // [R08]
    .sample   (in_sync[0]),
    .level    (pwm_level[0])
  );

  rmc_pwm_decode u_pwm1 (
    .pclk     (pclk),
    .presetn  (presetn),
    .mclk_en  (mclk_en),
    .timebase (gpiocfg[`RMC_P1_TB_LSB+1:`RMC_P1_TB_LSB]),  // [R08]
    .sample   (in_sync[1]),
    .level    (pwm_level[1])
  );

  // direction, output level and input format per pin
  assign gpio_oe    = {gpiocfg[`RMC_P1_DIR_BIT], gpiocfg[`RMC_P0_DIR_BIT]};  // [R07]
  assign gpio_out   = {gpiocfg[`RMC_P1_DAT_BIT], gpiocfg[`RMC_P0_DAT_BIT]};
  assign gpio_level = {gpiocfg[`RMC_P1_FMT_BIT] ? pwm_level[1] : in_sync[1],
                       gpiocfg[`RMC_P0_FMT_BIT] ? pwm_level[0] : in_sync[0]}; // [R07]

endmodule

// ---- test/rmc_regbank_asserts.sv ----
`timescale 1ns/100ps
`include "rmc_defs.vh"
// ----------
// register bank checker
// ----------
module rmc_regbank_asserts #(
  parameter MCLK_DIV = `RMC_MCLK_DIV
) (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0]  pstrb,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] prdata,
  input wire [1:0]  gpio_in,
  input wire [1:0]  gpio_out,
  input wire [1:0]  gpio_oe,
  input wire        section3_crc_check_enable,
  input wire [2:0]  test_dac2_level_select,
  input wire [6:0]  test_dac2_level,
  input wire        crc_error
);
  localparam logic [6:0] LV [8] = '{7'h01, 7'h02, 7'h04, 7'h09, 7'h12, 7'h24, 7'h7C, 7'h77};
  // write strobes for the C0h and C1h registers
  wire wr   = psel && penable && pwrite;
  wire w_s3 = wr && paddr == 12'h300;
  wire w_gp = wr && paddr == 12'h304;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_read_upper: assert property (psel && penable && !pwrite |-> pready && prdata[31:16] == 16'h0000)
    else $error("read access not clean");
  a_unmapped_err: assert property (psel && penable && paddr == 12'h000 |-> pslverr && prdata == 0)
    else $error("unmapped access accepted");
  a_enable_write: assert property (w_s3 && pstrb[1] |=> section3_crc_check_enable == $past(pwdata[15]))
    else $error("section 3 enable not written");
  a_select_write: assert property (w_s3 && pstrb[0] |=> test_dac2_level_select == $past(pwdata[2:0]))
    else $error("dac select not written");
  a_level_map: assert property (1'b1 |=> test_dac2_level == LV[$past(test_dac2_level_select)])
    else $error("dac level mismatch");
  a_oe_write: assert property (w_gp && pstrb[1] |=> gpio_oe == $past(pwdata[9:8]))
    else $error("pin direction not written");
  a_out_write: assert property (w_gp && pstrb[0] |=> gpio_out == $past(pwdata[1:0]))
    else $error("pin level not written");
  a_cfg_hold: assert property (!w_s3 |=> $stable(section3_crc_check_enable) && $stable(test_dac2_level_select))
    else $error("config moved without write");
  a_err_sticky: assert property (crc_error && !(wr && paddr == 12'h3C4) |=> crc_error)
    else $error("error flag dropped");
  c_enable: cover property (w_s3 && pwdata[15]);
  c_slverr: cover property (pslverr);
  c_err: cover property ($rose(crc_error));
endmodule

bind rmc_regbank rmc_regbank_asserts #(.MCLK_DIV(MCLK_DIV)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .prdata(prdata), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
  .section3_crc_check_enable(section3_crc_check_enable), .crc_error(crc_error),
  .test_dac2_level_select(test_dac2_level_select), .test_dac2_level(test_dac2_level));

// ---- test/rmc_regbank_tb_top.sv ----
`timescale 1ns/100ps
`include "rmc_defs.vh"
module rmc_regbank_tb_top;
  // ----------
  // signals
  // ----------
  localparam DIV = 2;
  localparam logic [6:0] LV [8] = '{7'h01, 7'h02, 7'h04, 7'h09, 7'h12, 7'h24, 7'h7C, 7'h77};
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [3:0]  pstrb = 4'hF;
  logic [1:0]  gpio_in = 2'h0;
  wire         pready, pslverr, crc_error, s3en;
  wire  [31:0] prdata;
  wire  [1:0]  gpio_out, gpio_oe;
  wire  [2:0]  sel;
  wire  [6:0]  lvl;
  integer      fails = 0, n_tests = 0, cyc = 0;

  always #4 pclk = ~pclk;
  rmc_regbank #(.MCLK_DIV(DIV)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .pslverr(pslverr), .prdata(prdata), .gpio_in(gpio_in),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .section3_crc_check_enable(s3en),
    .test_dac2_level_select(sel), .test_dac2_level(lvl), .crc_error(crc_error));

  // ----------
  // helpers
  // ----------
  task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
    n_tests = n_tests + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("BAD %0s exp %h got %h", nm, e, g);
    end
  endtask
  // one apb transfer, setup then access until pready
  task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // crc16, poly and init from the shared constants, msb first
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [15:0] d);
    for (int i = 15; i >= 0; i--)
      c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ `RMC_CRC_POLY) : {c[14:0], 1'b0};
    crc16 = c;
  endfunction
  task wr(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask
  task rc(input [95:0] nm, input [11:0] a, input [31:0] e);
    apb(1'b0, a, 32'h0, 4'hF);
    chk(nm, e, rd);
  endtask

  // ----------
  // scenarios
  // ----------
  task t_reset;
    rc("fill1", 12'h284, 32'h0);
    rc("fill2", 12'h288, 32'h0);
    rc("fill3", 12'h28C, 32'h0);
    rc("s2ref", 12'h2F8, 32'h0);
    rc("s3cfg", 12'h300, 32'h0);
    rc("gpiocfg", 12'h304, 32'h8000);
    chk("level", 7'h01, lvl);
    $display("test reset done");
  endtask
  task t_fill;
    wr(12'h284, 32'hFFFF);
    wr(12'h288, 32'hFFFF);
    wr(12'h28C, 32'hFFFF);
    apb(1'b1, 12'h28C, 32'h1234, 4'h1);
    rc("fill1", 12'h284, 32'hFFFF);
    rc("fill2", 12'h288, 32'hFF00);
    rc("fill3", 12'h28C, 32'hFF34);
    rc("s3cfg", 12'h300, 32'h0);
    @(negedge pclk);
    chk("oe", 2'h0, gpio_oe);
    chk("err", 1'b0, crc_error);
    wr(12'h2F8, 32'hA5C3);
    rc("s2ref", 12'h2F8, 32'hA5C3);
    $display("test filler done");
  endtask
  task t_cfg;
    for (int i = 0; i < 8; i++) begin
      wr(12'h300, i);
      @(posedge pclk);
      @(negedge pclk);
      chk("level", LV[i], lvl);
    end
    wr(12'h300, 32'hFFFF);
    rc("s3cfg", 12'h300, 32'h8007);
    chk("s3en", 1'b1, s3en);
    repeat (4) @(posedge pclk);
    chk("crcerr", 1'b1, crc_error);
    wr(12'h300, 32'h0);
    wr(12'h3C4, 32'h3);
    @(negedge pclk);
    chk("crcclr", 1'b0, crc_error);
    chk("s3en", 1'b0, s3en);
    $display("test section3 done");
  endtask
  task t_crc;
    logic [15:0] c2, c3;
    c2 = crc16(crc16(crc16(`RMC_CRC_INIT, 16'hFFFF), 16'hFF00), 16'hFF34);
    c3 = crc16(crc16(`RMC_CRC_INIT, 16'h8005), `RMC_RST_GPIOCFG);
    wr(12'h2F8, {16'h0000, c2});
    wr(12'h3C0, 32'h1);
    wr(12'h3C8, {16'h0000, c3});
    wr(12'h300, 32'h8005);
    repeat (4) @(posedge pclk);
    rc("crcok", 12'h3C4, 32'h0);
    apb(1'b1, 12'h288, 32'h0100, 4'h2);
    repeat (2) @(posedge pclk);
    rc("crcbad2", 12'h3C4, 32'h1);
    @(negedge pclk);
    chk("crcerr2", 1'b1, crc_error);
    wr(12'h288, 32'hFF00);
    wr(12'h3C4, 32'h3);
    wr(12'h300, 32'h0);
    wr(12'h3C0, 32'h0);
    rc("crcclr2", 12'h3C4, 32'h0);
    $display("test crc done");
  endtask
  task t_gpio;
    wr(12'h304, 32'h7FFF);
    rc("gpiocfg", 12'h304, 32'hFFFF);
    chk("oe", 2'h3, gpio_oe);
    chk("out", 2'h3, gpio_out);
    wr(12'h304, 32'h0);
    gpio_in <= 2'b10;
    repeat (4) @(posedge pclk);
    rc("pins", 12'h3CC, 32'h2);
    gpio_in <= 2'b00;
    for (int k = 0; k < 4; k++) begin
      wr(12'h304, 32'h0400 | (k << 4));
      gpio_in <= 2'b01;
      repeat (64 * DIV * (4 ** k) + 8) @(posedge pclk);
      rc("pwmhi", 12'h3CC, 32'h1);
      gpio_in <= 2'b00;
      repeat (64 * DIV * (4 ** k) + 8) @(posedge pclk);
      rc("pwmlo", 12'h3CC, 32'h0);
    end
    $display("test gpio done");
  endtask
  task t_bad;
    apb(1'b0, 12'h000, 32'h0, 4'hF);
    chk("err0", 1'b1, err);
    chk("data0", 32'h0, rd);
    apb(1'b1, 12'h285, 32'h0, 4'hF);
    chk("errmis", 1'b1, err);
    rc("fill1", 12'h284, 32'hFFFF);
    chk("errok", 1'b0, err);
    $display("test errors done");
  endtask

  // ----------
  // run control
  // ----------
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails = fails + 1;
      end_of_test;
    end
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_fill;
    t_cfg;
    t_crc;
    t_gpio;
    t_bad;
    end_of_test;
  end
endmodule
